// >>> rtl/tp_capture_pkg.sv
// Package with the register map, field positions and reset values of the probe capture block.
package tp_capture_pkg;

  // Number of probe channels and of capture events (two edges per channel).
  localparam int NUM_CH = 2;
  localparam int NUM_EV = 4;

  // Distance in bits between the channel one and channel two fields.
  localparam int CH_STRIDE = 8;

  // Configuration word fields, relative to a channel's base bit.
  localparam int CFG_EN = 0;
  localparam int CFG_CONT = 1;
  localparam int CFG_SRC = 2;
  localparam int CFG_RISE = 4;
  localparam int CFG_FALL = 5;

  // Status word fields, relative to a channel's base bit.
  localparam int STAT_USED = 0;
  localparam int STAT_STORE_R = 1;
  localparam int STAT_STORE_F = 2;
  localparam int STAT_TOG_R = 6;
  localparam int STAT_TOG_F = 7;

  // Value of the configuration word after reset.
  localparam logic [15:0] CFG_RESET = 16'h0033;

  // Reset values of the interrupt mask and the captured positions.
  localparam logic [3:0] MASK_RESET = 4'h0;
  localparam logic [31:0] POS_RESET = 32'h0000_0000;

  // Byte addresses of the registers on the bus.
  localparam logic [15:0] ADR_CFG = 16'h60b8;
  localparam logic [15:0] ADR_STAT = 16'h60bc;
  localparam logic [15:0] ADR_POS_R1 = 16'h60c0;
  localparam logic [15:0] ADR_POS_F1 = 16'h60c4;
  localparam logic [15:0] ADR_POS_R2 = 16'h60c8;
  localparam logic [15:0] ADR_POS_F2 = 16'h60cc;
  localparam logic [15:0] ADR_IRQ_STAT = 16'h60d0;
  localparam logic [15:0] ADR_IRQ_MASK = 16'h60d4;

endpackage : tp_capture_pkg

// >>> rtl/probe_pin_sync.sv
// Three-stage pin synchroniser with agreement filter and edge pulses.
`timescale 1ns/1ps
module probe_pin_sync (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_i,
  // Asynchronous pin.
  input wire logic pin_i,
  // Filtered level and one-cycle edge pulses.
  output logic level_o,
  output logic rise_o,
  output logic fall_o
);

  // All state of the synchroniser.
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic level;
    logic rise;
    logic fall;
  } sync_state_t;

  sync_state_t s_ff;
  sync_state_t nxt_s;

  // The first stage feeds only the second; the filter looks at stages two and three.
  always_comb
  begin
    nxt_s = s_ff;
    nxt_s.s1 = pin_i;
    nxt_s.s2 = s_ff.s1;
    nxt_s.s3 = s_ff.s2;
    nxt_s.rise = 1'b0;
    nxt_s.fall = 1'b0;
    // A change counts only once the two later stages agree on it.
    if (s_ff.s2 == s_ff.s3 && s_ff.s3 != s_ff.level)
    begin
      nxt_s.level = s_ff.s3;
      nxt_s.rise = s_ff.s3;
      nxt_s.fall = ~s_ff.s3;
    end
  end

  // State register with synchronous reset.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      s_ff <= '0;
    end
    else
    begin
      s_ff <= nxt_s;
    end
  end

  assign level_o = s_ff.level;
  assign rise_o = s_ff.rise;
  assign fall_o = s_ff.fall;

endmodule : probe_pin_sync

// >>> rtl/touch_probe_capture_control.sv
// Two-channel touch probe position capture with a classic Wishbone register slave.
//
// Contract
// - Channel one works only while bit 0 set
// - Channel two works only while bit 8 set
// - Bit 2 picks probe one or index
// - Bit 10 picks probe two or index
// - Bits 4/5 enable channel one edge captures
// - Bits 12/13 enable channel two edge captures
// - Configuration word resets to 0x0033
// - Read-only status shows use and stored flags
// - Each capture inverts its status toggle bit
// - Four signed 32-bit captured position values
//
// Chosen here: the Wishbone slave port.
`timescale 1ns/1ps
module touch_probe_capture_control (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave, classic cycle.
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [15:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // Probe pins and encoder index pulse, asynchronous.
  input wire logic probe1_i,
  input wire logic probe2_i,
  input wire logic index_i,
  // Actual position in user units, on this clock.
  input wire logic signed [31:0] position_i,
  // Level interrupt.
  output logic irq_o
);

  // All state of the block, registered as one word.
  typedef struct packed {
    logic [15:0] cfg;           // Configuration word.
    logic [3:0] stored;         // Stored flags, index ch*2+edge.
    logic [3:0] toggle;         // Update toggles, same index.
    logic [3:0][31:0] pos;      // Captured positions, same index.
    logic [3:0] irq_stat;       // Sticky capture events.
    logic [3:0] irq_mask;       // Interrupt enables.
    logic ack;                  // Bus acknowledge.
    logic [31:0] dat;           // Bus read data.
    logic irq;                  // Interrupt output.
  } state_t;

  state_t s_ff;
  state_t nxt_s;

  // Synchronised pin edges: index 0 probe one, 1 probe two, 2 index pulse.
  logic [2:0] pin_raw;
  logic [2:0] pin_rise;
  logic [2:0] pin_fall;

  // Capture events of this cycle, worked out in the main process.
  logic [3:0] cap_evt;

  // Bus strobes of the cycle in which the answer is given.
  logic bus_wr;
  logic bus_rd;

  assign pin_raw = {index_i, probe2_i, probe1_i};

  // Each pin passes its own three-stage synchroniser.
  generate
    for (genvar g = 0; g < 3; g++)
    begin : g_sync
      probe_pin_sync u_sync (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .pin_i(pin_raw[g]),
        .level_o(),
        .rise_o(pin_rise[g]),
        .fall_o(pin_fall[g])
      );
    end
  endgenerate

  // Address match, used by every register decode below.
  function automatic logic hit(input logic [15:0] adr, input logic [15:0] off);
    hit = (adr == off);
  endfunction : hit

  // Builds the read-only status word from the current state.
  function automatic logic [15:0] status_word(input state_t st);
    logic [15:0] w;
    int b;
    w = 16'h0000;
    for (int ch = 0; ch < tp_capture_pkg::NUM_CH; ch++)
    begin
      b = ch * tp_capture_pkg::CH_STRIDE;
      w[b + tp_capture_pkg::STAT_USED] = st.cfg[b + tp_capture_pkg::CFG_EN];
      w[b + tp_capture_pkg::STAT_STORE_R] = st.stored[ch * 2];
      w[b + tp_capture_pkg::STAT_STORE_F] = st.stored[ch * 2 + 1];
      w[b + tp_capture_pkg::STAT_TOG_R] = st.toggle[ch * 2];
      w[b + tp_capture_pkg::STAT_TOG_F] = st.toggle[ch * 2 + 1];
    end
    status_word = w;
  endfunction : status_word

  // Read multiplexer; unmapped addresses read as zero.
  function automatic logic [31:0] read_word(input state_t st, input logic [15:0] adr);
    logic [31:0] r;
    r = 32'h0000_0000;
    if (hit(adr, tp_capture_pkg::ADR_CFG))
    begin
      r = {16'h0000, st.cfg};
    end
    else if (hit(adr, tp_capture_pkg::ADR_STAT))
    begin
      r = {16'h0000, status_word(st)};
    end
    else if (hit(adr, tp_capture_pkg::ADR_POS_R1))
    begin
      r = st.pos[0];
    end
    else if (hit(adr, tp_capture_pkg::ADR_POS_F1))
    begin
      r = st.pos[1];
    end
    else if (hit(adr, tp_capture_pkg::ADR_POS_R2))
    begin
      r = st.pos[2];
    end
    else if (hit(adr, tp_capture_pkg::ADR_POS_F2))
    begin
      r = st.pos[3];
    end
    else if (hit(adr, tp_capture_pkg::ADR_IRQ_STAT))
    begin
      r = {28'h0000000, st.irq_stat};
    end
    else if (hit(adr, tp_capture_pkg::ADR_IRQ_MASK))
    begin
      r = {28'h0000000, st.irq_mask};
    end
    read_word = r;
  endfunction : read_word

  // Next-state logic: bus access, capture and interrupt.
  always_comb
  begin
    int b;
    int idx;
    logic en;
    logic cont;
    logic src;
    logic edge_en;
    logic trig;
    b = 0;
    idx = 0;
    en = 1'b0;
    cont = 1'b0;
    src = 1'b0;
    edge_en = 1'b0;
    trig = 1'b0;
    nxt_s = s_ff;
    cap_evt = 4'h0;

    // Answer one cycle after the request and drop ack right after.
    nxt_s.ack = cyc_i & stb_i & ~s_ff.ack;
    bus_wr = nxt_s.ack & we_i;
    bus_rd = nxt_s.ack & ~we_i;

    // Configuration write honours the two low byte lanes.
    if (bus_wr && hit(adr_i, tp_capture_pkg::ADR_CFG))
    begin
      if (sel_i[0])
      begin
        nxt_s.cfg[7:0] = dat_i[7:0];
      end
      if (sel_i[1])
      begin
        nxt_s.cfg[15:8] = dat_i[15:8];
      end
    end

    // Mask write uses the lowest lane only.
    if (bus_wr && hit(adr_i, tp_capture_pkg::ADR_IRQ_MASK) && sel_i[0])
    begin
      nxt_s.irq_mask = dat_i[3:0];
    end

    // Per channel and edge, the capture qualifies against the current setup.
    for (int ch = 0; ch < tp_capture_pkg::NUM_CH; ch++)
    begin
      b = ch * tp_capture_pkg::CH_STRIDE;
      en = s_ff.cfg[b + tp_capture_pkg::CFG_EN];
      cont = s_ff.cfg[b + tp_capture_pkg::CFG_CONT];
      src = s_ff.cfg[b + tp_capture_pkg::CFG_SRC];
      for (int e = 0; e < 2; e++)
      begin
        idx = ch * 2 + e;
        edge_en = s_ff.cfg[b + tp_capture_pkg::CFG_RISE + e];
        // The index pulse is shared; each channel has its own probe pin.
        if (src)
        begin
          trig = (e == 0) ? pin_rise[2] : pin_fall[2];
        end
        else
        begin
          trig = (e == 0) ? pin_rise[ch] : pin_fall[ch];
        end
        // Single mode takes only the first edge until the flag is cleared.
        cap_evt[idx] = en & edge_en & trig & (cont | ~s_ff.stored[idx]);
        if (cap_evt[idx])
        begin
          nxt_s.pos[idx] = position_i;
          nxt_s.stored[idx] = 1'b1;
          nxt_s.toggle[idx] = ~s_ff.toggle[idx];
        end
        else if (!en || !edge_en)
        begin
          // Clearing the enable drops the stored flag and re-arms the edge.
          nxt_s.stored[idx] = 1'b0;
        end
      end
    end

    // A read of the event register clears it, but a new event wins.
    if (bus_rd && hit(adr_i, tp_capture_pkg::ADR_IRQ_STAT))
    begin
      nxt_s.irq_stat = 4'h0;
    end
    nxt_s.irq_stat = nxt_s.irq_stat | cap_evt;

    // Read data is valid only in the acknowledge cycle.
    if (bus_rd)
    begin
      nxt_s.dat = read_word(s_ff, adr_i);
    end
    else
    begin
      nxt_s.dat = 32'h0000_0000;
    end

    // Interrupt follows the next state so it needs no extra cycle.
    nxt_s.irq = |(nxt_s.irq_stat & nxt_s.irq_mask);
  end

  // State register with synchronous reset to constants.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      s_ff.cfg <= tp_capture_pkg::CFG_RESET;
      s_ff.stored <= 4'h0;
      s_ff.toggle <= 4'h0;
      s_ff.pos <= {4{tp_capture_pkg::POS_RESET}};
      s_ff.irq_stat <= 4'h0;
      s_ff.irq_mask <= tp_capture_pkg::MASK_RESET;
      s_ff.ack <= 1'b0;
      s_ff.dat <= 32'h0000_0000;
      s_ff.irq <= 1'b0;
    end
    else
    begin
      s_ff <= nxt_s;
    end
  end

  // Outputs come straight from the state register.
  assign dat_o = s_ff.dat;
  assign ack_o = s_ff.ack;
  assign irq_o = s_ff.irq;

  // Checks run on the block clock and, all but a_cfg_reset_val, are silent during reset.
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  // A disabled channel one never holds a stored flag.
  a_ch1_off_idle: assert property (!s_ff.cfg[0] |=> s_ff.stored[1:0] == 2'b00)
    else $error("channel one stored flag while disabled");

  // A disabled channel two never holds a stored flag.
  a_ch2_off_idle: assert property (!s_ff.cfg[8] |=> s_ff.stored[3:2] == 2'b00)
    else $error("channel two stored flag while disabled");

  // Channel one on index source captures the position on the index rising edge.
  a_ch1_index_cap: assert property (
    (s_ff.cfg[0] && s_ff.cfg[2] && s_ff.cfg[4] && s_ff.cfg[1] && pin_rise[2])
    |=> s_ff.pos[0] == $past(position_i))
    else $error("channel one missed an index capture");

  // Channel two on its own input captures the probe two rising edge.
  a_ch2_probe_cap: assert property (
    (s_ff.cfg[8] && !s_ff.cfg[10] && s_ff.cfg[12] && s_ff.cfg[9] && pin_rise[1])
    |=> s_ff.pos[2] == $past(position_i) && s_ff.stored[2])
    else $error("channel two missed a probe capture");

  // With the falling enable clear, channel one never takes a falling edge.
  a_ch1_fall_off: assert property (!s_ff.cfg[5] |-> !cap_evt[1])
    else $error("channel one captured a disabled falling edge");

  // With the rising enable clear, channel two never takes a rising edge.
  a_ch2_rise_off: assert property (!s_ff.cfg[12] |-> !cap_evt[2])
    else $error("channel two captured a disabled rising edge");

  // After reset the configuration word holds its default.
  // The default disable would silence this check, since its trigger is the reset itself.
  a_cfg_reset_val: assert property (@(posedge clk_i) disable iff (1'b0)
    rst_i |=> s_ff.cfg == tp_capture_pkg::CFG_RESET)
    else $error("configuration word wrong after reset");

  // In single mode a stored rising value of channel one stays frozen.
  a_single_frozen: assert property (
    (s_ff.stored[0] && !s_ff.cfg[1] && s_ff.cfg[4] && s_ff.cfg[0]) |=> $stable(s_ff.pos[0]))
    else $error("single mode overwrote a stored position");

  // A status read returns channel two use as the configuration stood when it was taken.
  a_stat_used: assert property (
    (cyc_i && stb_i && !we_i && !ack_o && adr_i == tp_capture_pkg::ADR_STAT)
    |=> dat_o[8] == $past(s_ff.cfg[8]))
    else $error("status use bit disagrees with configuration");

  // A channel one falling capture inverts its toggle and raises its sticky event.
  a_toggle_flip: assert property (
    cap_evt[1] |=> s_ff.toggle[1] != $past(s_ff.toggle[1]) && s_ff.irq_stat[1])
    else $error("capture did not invert its toggle");

  // Channel two falling captures invert their own toggle and set the stored flag.
  a_ch2_fall_tog: assert property (
    cap_evt[3] |=> s_ff.toggle[3] != $past(s_ff.toggle[3]) && s_ff.stored[3])
    else $error("channel two falling capture did not invert its toggle");

  // Clearing the channel two falling enable drops its stored flag, which re-arms it.
  a_ch2_rearm: assert property (!s_ff.cfg[13] |=> !s_ff.stored[3])
    else $error("channel two stored flag survived a cleared enable");

  // The interrupt is high exactly while an unmasked event is pending.
  a_irq_level: assert property (irq_o == |(s_ff.irq_stat & s_ff.irq_mask))
    else $error("interrupt does not match pending events");

  // Every request is answered in the next cycle and ack lasts one cycle.
  a_ack_single: assert property ((cyc_i && stb_i && !ack_o) |=> ack_o ##1 !ack_o)
    else $error("bus acknowledge timing wrong");

endmodule : touch_probe_capture_control

// >>> tb/probe_partner.sv
// Probe pins and encoder index source standing at the far side of the capture block.
`timescale 1ns/1ps
module probe_partner (
  // Clock.
  input wire logic clk_i,
  // Probe pins and index pulse.
  output logic probe1_o,
  output logic probe2_o,
  output logic index_o
);
  // Pins rest low, as an idle probe without contact.
  initial
  begin
    probe1_o = 1'b0;
    probe2_o = 1'b0;
    index_o = 1'b0;
  end

  // Flip one pin after an edge; callers hold it well past the filter length.
  task automatic toggle(input int p);
    @(posedge clk_i);
    case (p)
      0: probe1_o <= ~probe1_o;
      1: probe2_o <= ~probe2_o;
      default: index_o <= ~index_o;
    endcase
  endtask : toggle
endmodule : probe_partner

// >>> tb/testbench.sv
// Self-checking bench with a reference model of the probe capture block.
`timescale 1ns/1ps
module testbench;
  // Design inputs and outputs.
  logic clk_i, rst_i, cyc_i, stb_i, we_i, ack_o, irq_o;
  logic [15:0] adr_i;
  logic [3:0] sel_i;
  logic [31:0] dat_i, dat_o, rnd, rd;
  logic signed [31:0] position_i;
  logic probe1_i, probe2_i, index_i;
  int n_mismatch, check_count, cycles;
  // Reference model state: config, stored flags, toggles, events, mask.
  logic [15:0] cfg_m;
  logic [3:0] stored_m, tog_m, irqs_m, mask_m;
  logic [31:0] pos_m [4];
  logic [15:0] corner [10] = '{16'h0031, 16'h0031, 16'h0001, 16'h0031, 16'h0035,
    16'h0013, 16'h0032, 16'h3300, 16'h3735, 16'h2700};

  touch_probe_capture_control DUT (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
    .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
    .dat_o(dat_o), .ack_o(ack_o), .probe1_i(probe1_i), .probe2_i(probe2_i),
    .index_i(index_i), .position_i(position_i), .irq_o(irq_o));
  probe_partner pp (.clk_i(clk_i), .probe1_o(probe1_i), .probe2_o(probe2_i),
    .index_o(index_i));

  // Free-running 125 MHz clock.
  initial
  begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end

  // Hang guard; the whole run needs well under a third of this.
  always @(posedge clk_i)
  begin
    cycles = cycles + 1;
    if (cycles == 20000)
    begin
      n_mismatch++;
      conclude();
    end
  end

  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction : lfsr

  // Status word expected from the model state.
  function automatic logic [31:0] stat_f();
    logic [31:0] s;
    s = 32'h0;
    for (int c = 0; c < 2; c++)
    begin
      s[c*8] = cfg_m[c*8];
      s[c*8+1] = stored_m[c*2];
      s[c*8+2] = stored_m[c*2+1];
      s[c*8+6] = tog_m[c*2];
      s[c*8+7] = tog_m[c*2+1];
    end
    return s;
  endfunction : stat_f

  task chk(input logic [31:0] g, input logic [31:0] e);
    check_count++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk

  task chk_bit(input logic g, input logic e);
    check_count++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk_bit

  // Classic cycle: hold the request until ack is seen at an edge, then release.
  task wb(input logic w, input logic [15:0] a, input logic [31:0] d);
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    dat_i <= d;
    do @(posedge clk_i); while (ack_o !== 1'b1);
    rd = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    we_i <= 1'b0;
  endtask : wb

  // Write and mirror the effect in the model; stored flags drop with their enables.
  task wr(input logic [15:0] a, input logic [31:0] d);
    wb(1'b1, a, d);
    if (a == tp_capture_pkg::ADR_CFG && sel_i[0])
      cfg_m[7:0] = d[7:0];
    if (a == tp_capture_pkg::ADR_CFG && sel_i[1])
      cfg_m[15:8] = d[15:8];
    if (a == tp_capture_pkg::ADR_IRQ_MASK && sel_i[0])
      mask_m = d[3:0];
    for (int i = 0; i < 4; i++)
      if (!cfg_m[(i/2)*8] || !cfg_m[(i/2)*8+4+i%2])
        stored_m[i] = 1'b0;
  endtask : wr

  task rd_chk(input logic [15:0] a, input logic [31:0] e);
    wb(1'b0, a, 32'h0);
    chk(rd, e);
  endtask : rd_chk

  // Flip one pin with a held position, then predict which channels capture it.
  task fire(input int p, input logic [31:0] v);
    logic lv;
    int e;
    @(posedge clk_i);
    position_i <= v;
    pp.toggle(p);
    repeat (12) @(posedge clk_i);
    lv = (p == 0) ? probe1_i : ((p == 1) ? probe2_i : index_i);
    e = lv ? 0 : 1;
    for (int c = 0; c < 2; c++)
      if (((cfg_m[c*8+2]) ? 2 : c) == p && cfg_m[c*8] && cfg_m[c*8+4+e]
          && (cfg_m[c*8+1] || !stored_m[c*2+e]))
      begin
        pos_m[c*2+e] = v;
        stored_m[c*2+e] = 1'b1;
        tog_m[c*2+e] = ~tog_m[c*2+e];
        irqs_m[c*2+e] = 1'b1;
      end
    chk_bit(irq_o, |(irqs_m & mask_m));
  endtask : fire

  // Read every register back; reading the event register empties it.
  task check_all();
    rd_chk(tp_capture_pkg::ADR_CFG, {16'h0, cfg_m});
    rd_chk(tp_capture_pkg::ADR_STAT, stat_f());
    for (int i = 0; i < 4; i++)
      rd_chk(tp_capture_pkg::ADR_POS_R1 + 16'(4*i), pos_m[i]);
    rd_chk(16'h60e0, 32'h0);
    rd_chk(tp_capture_pkg::ADR_IRQ_MASK, {28'h0, mask_m});
    rd_chk(tp_capture_pkg::ADR_IRQ_STAT, {28'h0, irqs_m});
    irqs_m = 4'h0;
    repeat (2) @(posedge clk_i);
    chk_bit(irq_o, 1'b0);
  endtask : check_all

  task conclude();
    $display("checks=%0d mismatches=%0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : conclude

  // Reset, corner configurations, then random traffic.
  initial
  begin
    {cyc_i, stb_i, we_i, rst_i} = 4'h1;
    adr_i = 16'h0;
    sel_i = 4'hf;
    dat_i = 32'h0;
    position_i = 32'h0;
    rnd = 32'h57ba;
    cfg_m = 16'h0033;
    {stored_m, tog_m, irqs_m, mask_m} = 16'h0;
    pos_m = '{4{32'h0}};
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    check_all();
    wr(tp_capture_pkg::ADR_IRQ_MASK, 32'hf);
    fire(0, 32'h8000_0000);
    fire(0, 32'h7fff_ffff);
    fire(0, 32'h0000_0001);
    check_all();
    // Single mode, re-arm, index source, edge masks, channel off, channel two.
    foreach (corner[k])
    begin
      wr(tp_capture_pkg::ADR_CFG, {16'h0, corner[k]});
      for (int p = 0; p < 3; p++)
      begin
        rnd = lfsr(rnd);
        fire(p, rnd);
        fire(p, ~rnd);
      end
      check_all();
    end
    for (int n = 0; n < 40; n++)
    begin
      rnd = lfsr(rnd);
      if (rnd[0])
        wr(tp_capture_pkg::ADR_CFG, rnd & 32'h3737);
      if (rnd[1])
        wr(tp_capture_pkg::ADR_IRQ_MASK, {28'h0, rnd[7:4]});
      wr(tp_capture_pkg::ADR_STAT, rnd);
      wr(tp_capture_pkg::ADR_POS_F1, ~rnd);
      rnd = lfsr(rnd);
      fire(int'(rnd[1:0] % 3), rnd);
      check_all();
    end
    // Upper lane only: channel two is set up, channel one and the mask keep theirs.
    sel_i <= 4'h2;
    wr(tp_capture_pkg::ADR_CFG, 32'h0000_1133);
    wr(tp_capture_pkg::ADR_IRQ_MASK, 32'h0000_0000);
    sel_i <= 4'hf;
    fire(1, 32'h1234_5678);
    check_all();
    // Mid-run reset; pins go back to rest first, so that no false edge follows it.
    if (probe1_i)
      fire(0, 32'h0000_0000);
    if (probe2_i)
      fire(1, 32'h0000_0000);
    if (index_i)
      fire(2, 32'h0000_0000);
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    cfg_m = 16'h0033;
    {stored_m, tog_m, irqs_m, mask_m} = 16'h0;
    pos_m = '{4{32'h0}};
    check_all();
    fire(0, 32'h0000_5a5a);
    check_all();
    conclude();
  end
endmodule : testbench
